/* rtl/blink_code_seq.sv */
// Blink-code sequencer: header, digits and gaps on one LED
`timescale 1ns/1ps
`include "relay_ind_regs.svh"
module blink_code_seq import relay_ind_pkg::*; #(
	parameter int DIGITS = 4
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic en_i,
	input wire logic [15:0] code_i,
	input wire logic [2:0] ndig_i,
	output logic led_o
);
	if (DIGITS != 4) begin : g_chk
		$error("blink_code_seq serves exactly four digits");
	end

	blink_state_e st, next_st;
	logic [4:0] tcnt, next_tcnt;
	logic [4:0] fcnt, next_fcnt;
	logic [1:0] dig, next_dig;
	logic next_led;
	logic [3:0] digit;
	logic [4:0] target;
	logic [4:0] dur;

	always_comb begin
		digit = code_i[15 - 4 * dig -: 4];
		target = (digit == 4'h0) ? 5'(`SR_ZERO_FLASHES) : {1'b0, digit};
		unique case (st)
			BL_HDR_ON, BL_HDR_OFF: dur = 5'(`SR_SHORT_TICKS);
			BL_DIG_ON: dur = 5'(`SR_LONG_ON_TICKS);
			BL_DIG_OFF: dur = 5'(`SR_LONG_OFF_TICKS);
			BL_PAUSE, BL_GAP: dur = 5'(`SR_GAP_TICKS);
			default: dur = 5'h01;
		endcase
	end

	always_comb begin
		next_st = st;
		next_tcnt = tcnt;
		next_fcnt = fcnt;
		next_dig = dig;
		if (!en_i) begin
			next_st = BL_IDLE;
		end else if (st == BL_IDLE) begin
			next_st = BL_HDR_ON;
			next_tcnt = 5'h00;
			next_fcnt = 5'h00;
			next_dig = 2'h0;
		end else if (tick_i) begin
			next_tcnt = tcnt + 5'h01;
			if (tcnt == dur - 5'h01) begin
				next_tcnt = 5'h00;
				unique case (st)
					BL_HDR_ON: next_st = BL_HDR_OFF;
					BL_HDR_OFF: begin
						if (fcnt == 5'(`SR_HDR_FLASHES - 1)) begin
							next_st = BL_PAUSE;
							next_fcnt = 5'h00;
						end else begin
							next_st = BL_HDR_ON;
							next_fcnt = fcnt + 5'h01;
						end
					end
					BL_PAUSE: next_st = BL_DIG_ON;
					BL_DIG_ON: next_st = BL_DIG_OFF;
					BL_DIG_OFF: begin
						if (fcnt == target - 5'h01) begin
							next_fcnt = 5'h00;
							next_st = BL_GAP;
							// Wrap restarts the header, so the code repeats
							next_dig = ({1'b0, dig} == ndig_i - 3'h1) ? 2'h0 : dig + 2'h1;
						end else begin
							next_st = BL_DIG_ON;
							next_fcnt = fcnt + 5'h01;
						end
					end
					BL_GAP: next_st = (dig == 2'h0) ? BL_HDR_ON : BL_DIG_ON;
					default: next_st = BL_IDLE;
				endcase
			end
		end
		next_led = en_i && (next_st == BL_HDR_ON || next_st == BL_DIG_ON);
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st <= BL_IDLE;
			tcnt <= 5'h00;
			fcnt <= 5'h00;
			dig <= 2'h0;
			led_o <= 1'b0;
		end else begin
			st <= next_st;
			tcnt <= next_tcnt;
			fcnt <= next_fcnt;
			dig <= next_dig;
			led_o <= next_led;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_header_three: assert property (
		(st == BL_HDR_OFF && next_st == BL_PAUSE && en_i) |-> fcnt == 5'h02)
		else $error("header did not end after three short flashes");
	a_zero_sixteen: assert property (
		(st == BL_DIG_OFF && next_st == BL_GAP && en_i && digit == 4'h0) |-> fcnt == 5'h0F)
		else $error("zero digit did not give sixteen flashes");
	a_digit_count: assert property (
		(st == BL_DIG_OFF && next_st == BL_GAP && en_i && digit != 4'h0)
		|-> fcnt == {1'b0, digit} - 5'h01)
		else $error("digit flash count differs from digit value");
	c_code_wraps: cover property (st == BL_GAP && en_i ##1 st == BL_HDR_ON);
endmodule

/* rtl/safety_relay_indicator.sv */
// Safety relay status, supply monitor and fault indication
`timescale 1ns/1ps
`include "relay_ind_regs.svh"
module safety_relay_indicator import relay_ind_pkg::*; #(
	parameter int LOSS_CYC = `SR_LOSS_CYC,
	parameter int OFF_CYC = `SR_OFF_CYC,
	parameter int TICK_CYC = `SR_TICK_CYC,
	parameter int TP_PERIOD_CYC = `SR_TP_PERIOD_CYC,
	parameter int TP_CYC = `SR_TP_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic supply_ok_i,
	input wire logic mode_valid_i,
	input wire logic start_done_i,
	input wire logic chan_req_i,
	input wire logic feedback_open_i,
	input wire logic single_channel_i,
	input wire logic and_link_input_i,
	input wire logic fault_i,
	input wire logic [15:0] fault_code_i,
	input wire logic [2:0] fault_ndig_i,
	output logic power_led_o,
	output logic first_channel_indicator_o,
	output logic second_channel_indicator_o,
	output logic safety_out14_o,
	output logic safety_out24_o,
	output logic error_o
);
	localparam int LOSS_W = $clog2(LOSS_CYC + 1);
	localparam int OFF_W = $clog2(OFF_CYC + 1);
	localparam int TICK_W = $clog2(TICK_CYC + 1);
	localparam int TP_W = $clog2(TP_PERIOD_CYC + 1);

	if (LOSS_CYC < 2 || OFF_CYC <= LOSS_CYC || TICK_CYC < 2
		|| TP_CYC < 1 || TP_PERIOD_CYC <= TP_CYC) begin : g_chk
		$error("safety_relay_indicator: timing parameters out of range");
	end

	relay_state_e state, next_state;
	logic [LOSS_W-1:0] loss_cnt, next_loss_cnt;
	logic [OFF_W-1:0] off_cnt, next_off_cnt;
	logic off_long, next_off_long;
	logic [TICK_W-1:0] pre_cnt, next_pre_cnt;
	logic tick, next_tick;
	logic [TP_W-1:0] tp_cnt, next_tp_cnt;
	logic [2:0] init_cnt, next_init_cnt;
	logic fault_lat, next_fault_lat;
	logic [15:0] code, next_code;
	logic [2:0] ndig, next_ndig;
	logic pwr_ph, next_pwr_ph;
	logic alt_ph, next_alt_ph;
	logic next_power_led, next_first_led, next_second_led;
	logic next_out14, next_out24, next_error;
	logic supply_err, tp_active, drive, alt_req, code_led, restart;

	// Prescaler and test-pulse timer
	always_comb begin
		next_pre_cnt = pre_cnt + TICK_W'(1);
		next_tick = 1'b0;
		if (pre_cnt == TICK_W'(TICK_CYC - 1)) begin
			next_pre_cnt = '0;
			next_tick = 1'b1;
		end
		next_tp_cnt = (tp_cnt == TP_W'(TP_PERIOD_CYC - 1)) ? '0 : tp_cnt + TP_W'(1);
		tp_active = tp_cnt < TP_W'(TP_CYC);
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pre_cnt <= '0;
			tick <= 1'b0;
			tp_cnt <= '0;
		end else begin
			pre_cnt <= next_pre_cnt;
			tick <= next_tick;
			tp_cnt <= next_tp_cnt;
		end
	end

	// Supply monitor; outage shorter than the loss time is ridden through
	always_comb begin
		next_loss_cnt = loss_cnt;
		next_off_cnt = off_cnt;
		next_off_long = off_long;
		if (supply_ok_i) begin
			next_loss_cnt = '0;
			next_off_cnt = '0;
		end else begin
			if (loss_cnt != LOSS_W'(LOSS_CYC)) begin
				next_loss_cnt = loss_cnt + LOSS_W'(1);
			end
			if (off_cnt != OFF_W'(OFF_CYC)) begin
				next_off_cnt = off_cnt + OFF_W'(1);
			end else begin
				next_off_long = 1'b1;
			end
		end
		supply_err = !supply_ok_i && loss_cnt == LOSS_W'(LOSS_CYC - 1);
		restart = state == ST_ERROR && supply_ok_i && off_long;
		if (restart) begin
			next_off_long = 1'b0;
		end
	end

	// Operating state and fault latch
	always_comb begin
		next_state = state;
		next_init_cnt = init_cnt;
		next_fault_lat = fault_lat;
		next_code = code;
		next_ndig = ndig;
		if (restart) begin
			next_state = ST_INIT;
			next_init_cnt = 3'h0;
			next_fault_lat = 1'b0;
		end else if (state != ST_ERROR) begin
			// First fault wins the display; later ones are ignored until a restart
			if (supply_err) begin
				next_fault_lat = 1'b1;
				next_code = `SR_SUPPLY_CODE;
				next_ndig = `SR_SUPPLY_NDIG;
				next_state = ST_ERROR;
			end else if (state == ST_INIT && and_link_input_i) begin
				// Linked units share supply; upstream output must still be low
				next_fault_lat = 1'b1;
				next_code = `SR_ANDLINK_CODE;
				next_ndig = `SR_ANDLINK_NDIG;
				next_state = ST_ERROR;
			end else if (fault_i) begin
				next_fault_lat = 1'b1;
				next_code = fault_code_i;
				next_ndig = (fault_ndig_i == 3'h0 || fault_ndig_i > 3'h4) ? 3'h4 : fault_ndig_i;
				next_state = ST_ERROR;
			end else begin
				unique case (state)
					ST_INIT: begin
						if (tick) begin
							next_init_cnt = init_cnt + 3'h1;
						end
						if (tick && init_cnt == 3'(`SR_INIT_TICKS - 1)) begin
							next_state = ST_WAIT;
						end
					end
					ST_WAIT: begin
						if (mode_valid_i && start_done_i) begin
							next_state = ST_RUN;
						end
					end
					ST_RUN: begin
						if (!mode_valid_i || !start_done_i) begin
							next_state = ST_WAIT;
						end
					end
					ST_ERROR: next_state = ST_ERROR;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= ST_INIT;
			init_cnt <= 3'h0;
			loss_cnt <= '0;
			off_cnt <= '0;
			off_long <= 1'b0;
			fault_lat <= 1'b0;
			code <= 16'h0000;
			ndig <= 3'h1;
		end else begin
			state <= next_state;
			init_cnt <= next_init_cnt;
			loss_cnt <= next_loss_cnt;
			off_cnt <= next_off_cnt;
			off_long <= next_off_long;
			fault_lat <= next_fault_lat;
			code <= next_code;
			ndig <= next_ndig;
		end
	end

	blink_code_seq #(
		.DIGITS(4)
	) u_code (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.en_i(fault_lat),
		.code_i(code),
		.ndig_i(ndig),
		.led_o(code_led)
	);

	// Outputs and LEDs
	always_comb begin
		drive = state == ST_RUN && chan_req_i && and_link_input_i;
		alt_req = (state == ST_WAIT || state == ST_RUN)
			&& (feedback_open_i || single_channel_i);
		next_pwr_ph = tick ? !pwr_ph : pwr_ph;
		next_alt_ph = tick ? !alt_ph : alt_ph;
		next_out14 = drive && !tp_active;
		next_out24 = drive && !tp_active;
		unique case (state)
			ST_INIT, ST_WAIT: next_power_led = next_pwr_ph;
			ST_RUN: next_power_led = 1'b1;
			ST_ERROR: next_power_led = 1'b0;
		endcase
		if (fault_lat) begin
			next_first_led = code_led;
			next_second_led = 1'b0;
		end else if (alt_req) begin
			next_first_led = next_alt_ph;
			next_second_led = !next_alt_ph;
		end else begin
			// LED shows drive, not the pulsed pin, to avoid flicker
			next_first_led = drive;
			next_second_led = drive;
		end
		next_error = next_state == ST_ERROR;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pwr_ph <= 1'b0;
			alt_ph <= 1'b0;
			power_led_o <= 1'b0;
			first_channel_indicator_o <= 1'b0;
			second_channel_indicator_o <= 1'b0;
			safety_out14_o <= 1'b0;
			safety_out24_o <= 1'b0;
			error_o <= 1'b0;
		end else begin
			pwr_ph <= next_pwr_ph;
			alt_ph <= next_alt_ph;
			power_led_o <= next_power_led;
			first_channel_indicator_o <= next_first_led;
			second_channel_indicator_o <= next_second_led;
			safety_out14_o <= next_out14;
			safety_out24_o <= next_out24;
			error_o <= next_error;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_loss_to_error: assert property (
		(!supply_ok_i && loss_cnt == LOSS_W'(LOSS_CYC - 1) && state != ST_ERROR)
		|=> state == ST_ERROR && error_o && fault_lat)
		else $error("supply loss did not enter error");
	a_error_outputs_low: assert property (
		(state == ST_ERROR && $past(state) == ST_ERROR)
		|-> !safety_out14_o && !safety_out24_o && !power_led_o)
		else $error("outputs active in error state");
	a_error_latched: assert property (
		(state == ST_ERROR && !(supply_ok_i && off_long)) |=> state == ST_ERROR)
		else $error("error left without a long supply cycle");
	a_init_blinks: assert property (
		((state == ST_INIT || state == ST_WAIT) && tick && !restart
		&& ($past(state) == ST_INIT || $past(state) == ST_WAIT)
		&& next_state != ST_ERROR && next_state != ST_RUN)
		|=> power_led_o != $past(power_led_o))
		else $error("power LED not blinking before ready");
	a_run_power_on: assert property (
		(state == ST_RUN ##1 state == ST_RUN) |=> power_led_o)
		else $error("power LED not steady when ready");
	a_led_first: assert property (
		safety_out14_o |-> first_channel_indicator_o || $past(alt_req))
		else $error("first channel LED dark with output 14 high");
	a_led_second: assert property (
		safety_out24_o |-> second_channel_indicator_o || $past(alt_req))
		else $error("second channel LED dark with output 24 high");
	a_test_pulse: assert property (
		(drive && tp_cnt == '0) |=> !safety_out14_o && !safety_out24_o)
		else $error("no test pulse on driven outputs");
	a_and_link_low: assert property (
		!and_link_input_i |=> !safety_out14_o && !safety_out24_o)
		else $error("AND-link low did not force outputs low");
	a_and_link_code: assert property (
		(state == ST_INIT && and_link_input_i && !supply_err && !restart)
		|=> fault_lat && code == `SR_ANDLINK_CODE)
		else $error("unexpected AND-link state not coded");
	a_fault_priority: assert property (
		(fault_lat && $past(fault_lat)) |-> first_channel_indicator_o == $past(code_led))
		else $error("coded fault not shown on first channel LED");

	c_run_reached: cover property (state == ST_WAIT ##1 state == ST_RUN);
	c_supply_error: cover property (supply_err ##1 state == ST_ERROR);
	c_restart: cover property (restart ##1 state == ST_INIT);
	c_alternate: cover property (alt_req && tick);
endmodule

/* shared/relay_ind_pkg.sv */
// State types of the relay indicator
package relay_ind_pkg;
	typedef enum logic [1:0] {
		ST_INIT = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN = 2'h2,
		ST_ERROR = 2'h3
	} relay_state_e;

	typedef enum logic [2:0] {
		BL_IDLE = 3'h0,
		BL_HDR_ON = 3'h1,
		BL_HDR_OFF = 3'h2,
		BL_PAUSE = 3'h3,
		BL_DIG_ON = 3'h4,
		BL_DIG_OFF = 3'h5,
		BL_GAP = 3'h6
	} blink_state_e;
endpackage

/* shared/relay_ind_regs.svh */
// Timing counts and fixed codes of the relay indicator
`ifndef RELAY_IND_REGS_SVH
`define RELAY_IND_REGS_SVH

`define SR_CLK_KHZ 10000
`define SR_LOSS_MS 20
`define SR_LOSS_CYC (`SR_LOSS_MS * `SR_CLK_KHZ)
`define SR_OFF_MS 1000
`define SR_OFF_CYC (`SR_OFF_MS * `SR_CLK_KHZ)
`define SR_TICK_MS 100
`define SR_TICK_CYC (`SR_TICK_MS * `SR_CLK_KHZ)
`define SR_SHORT_MS 200
`define SR_SHORT_TICKS (`SR_SHORT_MS / `SR_TICK_MS)
`define SR_LONG_ON_MS 1000
`define SR_LONG_ON_TICKS (`SR_LONG_ON_MS / `SR_TICK_MS)
`define SR_LONG_OFF_MS 1000
`define SR_LONG_OFF_TICKS (`SR_LONG_OFF_MS / `SR_TICK_MS)
`define SR_GAP_MS 2000
`define SR_GAP_TICKS (`SR_GAP_MS / `SR_TICK_MS)
`define SR_INIT_MS 500
`define SR_INIT_TICKS (`SR_INIT_MS / `SR_TICK_MS)
`define SR_TP_US 500
`define SR_TP_CYC (`SR_TP_US * `SR_CLK_KHZ / 1000)
`define SR_TP_PERIOD_MS 10
`define SR_TP_PERIOD_CYC (`SR_TP_PERIOD_MS * `SR_CLK_KHZ)
`define SR_HDR_FLASHES 3
`define SR_ZERO_FLASHES 16
`define SR_ANDLINK_CODE 16'h1500
`define SR_ANDLINK_NDIG 3'h2
`define SR_SUPPLY_CODE 16'h5A00
`define SR_SUPPLY_NDIG 3'h2

`endif

/* sim/test_safety_relay_fault_blink_indicator.sv */
// Self-checking bench of the relay indicator
`timescale 1ns/1ps
module test_safety_relay_fault_blink_indicator;
	localparam int LOSS = 20, OFF = 100, TICK = 4, TPP = 16, TPC = 2;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, supply_ok = 1'b1, mode_valid = 1'b0;
	logic start_done = 1'b0, chan_req = 1'b0, fb_open = 1'b0, single_ch = 1'b0;
	logic link_req = 1'b0, fault = 1'b0;
	logic [15:0] fcode = 16'h0000;
	logic [2:0] fndig = 3'h0;
	logic and_link, pwr, led1, led2, out14, out24, err;
	int n_fail = 0, num_checks = 0, ln, p, c1, c2, bo, j;
	int cap[$], expq[$];
	logic [31:0] rs = 32'h00000044;

	always #50 clk_sys_i = ~clk_sys_i;

	upstream_unit partner (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .out_req_i(link_req),
		.and_link_o(and_link));
	safety_relay_indicator #(.LOSS_CYC(LOSS), .OFF_CYC(OFF), .TICK_CYC(TICK),
		.TP_PERIOD_CYC(TPP), .TP_CYC(TPC)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.supply_ok_i(supply_ok), .mode_valid_i(mode_valid), .start_done_i(start_done),
		.chan_req_i(chan_req), .feedback_open_i(fb_open), .single_channel_i(single_ch),
		.and_link_input_i(and_link), .fault_i(fault), .fault_code_i(fcode),
		.fault_ndig_i(fndig), .power_led_o(pwr), .first_channel_indicator_o(led1),
		.second_channel_indicator_o(led2), .safety_out14_o(out14),
		.safety_out24_o(out24), .error_o(err));

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// Digit zero cannot be shown as no flashes
	function automatic int flashes(logic [3:0] d);
		return (d == 4'h0) ? 16 : int'(d);
	endfunction

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic step(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic wait_err(logic v, int lim);
		int i;
		for (i = 0; i < lim && err !== v; i++) step(1);
		check("error_o", err, v);
		if (err !== v) report_and_stop();
	endtask

	task automatic power_up();
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		supply_ok <= 1'b1;
		mode_valid <= 1'b0;
		start_done <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rst_i <= 1'b0;
	endtask

	task automatic lit(int n);
		p = 0;
		c1 = 0;
		c2 = 0;
		bo = 0;
		repeat (n) begin
			step(1);
			p += (pwr === 1'b1);
			c1 += (led1 === 1'b1);
			c2 += (led2 === 1'b1);
			bo += (led1 === 1'b1 && led2 === 1'b1);
		end
	endtask

	task automatic drive_window(logic on, int lows_exp);
		int lows;
		lows = 0;
		repeat (TPP) begin
			step(1);
			lows += (out14 !== 1'b1) + (out24 !== 1'b1);
			check("first_channel_indicator_o", led1, on);
			check("second_channel_indicator_o", led2, on);
		end
		check("safety output low cycles", lows, lows_exp);
	endtask

	task automatic capture(int n, logic outs_low);
		cap = {};
		ln = 0;
		repeat (n) begin
			step(1);
			check("second_channel_indicator_o", led2, 1'b0);
			if (outs_low) check("safety outputs", {out14, out24}, 2'b00);
			if (led1 === 1'b1) begin
				ln++;
			end else if (ln > 0) begin
				cap.push_back(ln);
				ln = 0;
			end
		end
	endtask

	task automatic check_code(logic [15:0] code, int nd);
		int i, k;
		expq = {};
		repeat (3) expq.push_back(2 * TICK);
		for (k = 0; k < nd; k++) begin
			repeat (flashes(code[15 - 4 * k -: 4])) expq.push_back(10 * TICK);
		end
		// Skip a partial first flash: the header is three shorts then a long
		i = 0;
		while (i + 3 < cap.size() && !(cap[i] == 2 * TICK && cap[i + 1] == 2 * TICK &&
			cap[i + 2] == 2 * TICK && cap[i + 3] != 2 * TICK)) i++;
		for (k = 0; k < expq.size(); k++) begin
			check("flash length", cap[i + k], expq[k]);
		end
		check("repeated header", cap[i + expq.size()], 2 * TICK);
	endtask

	initial begin
		power_up();
		step(3);
		lit(4 * TICK);
		check("power LED blink", p, 2 * TICK);
		step(10);
		@(posedge clk_sys_i);
		mode_valid <= 1'b1;
		start_done <= 1'b1;
		link_req <= 1'b1;
		step(5);
		lit(TPP);
		check("power LED steady", p, TPP);
		@(posedge clk_sys_i);
		chan_req <= 1'b1;
		step(3);
		drive_window(1'b1, 2 * TPC);
		@(posedge clk_sys_i);
		link_req <= 1'b0;
		step(3);
		drive_window(1'b0, 2 * TPP);
		@(posedge clk_sys_i);
		link_req <= 1'b1;
		$display("test run outputs done");
		// Random short supply dips and channel requests
		for (j = 0; j < 20; j++) begin
			@(posedge clk_sys_i);
			supply_ok <= 1'b0;
			chan_req <= 1'(rnd() % 2);
			repeat (1 + rnd() % (LOSS - 1)) @(posedge clk_sys_i);
			supply_ok <= 1'b1;
			step(3);
			check("error_o", err, 1'b0);
			check("first_channel_indicator_o", led1, chan_req);
		end
		@(posedge clk_sys_i);
		fb_open <= 1'b1;
		step(2);
		lit(4 * TICK);
		check("alternate ch1", c1, 2 * TICK);
		check("alternate ch2", c2, 2 * TICK);
		check("both lit", bo, 0);
		@(posedge clk_sys_i);
		fb_open <= 1'b0;
		single_ch <= 1'b1;
		step(2);
		lit(4 * TICK);
		check("alternate single", c1 + c2, 4 * TICK);
		@(posedge clk_sys_i);
		single_ch <= 1'b0;
		start_done <= 1'b0;
		step(2);
		lit(4 * TICK);
		check("power LED blink after start lost", p, 2 * TICK);
		check("channel LEDs after start lost", c1 + c2, 0);
		$display("test dips and alternate done");
		@(posedge clk_sys_i);
		supply_ok <= 1'b0;
		step(1);
		wait_err(1'b1, LOSS + 3);
		@(posedge clk_sys_i);
		supply_ok <= 1'b1;
		step(2);
		check("power LED in error", pwr, 1'b0);
		capture(3200, 1'b1);
		check("error latched", err, 1'b1);
		check_code(16'h5A00, 2);
		$display("test supply error done");
		// Restart with the link high during init
		@(posedge clk_sys_i);
		supply_ok <= 1'b0;
		repeat (OFF + 5) @(posedge clk_sys_i);
		supply_ok <= 1'b1;
		step(1);
		wait_err(1'b0, 10);
		step(6 * TICK);
		capture(1700, 1'b0);
		check_code(16'h1500, 2);
		$display("test link fault done");
		@(posedge clk_sys_i);
		link_req <= 1'b0;
		power_up();
		step(6 * TICK);
		@(posedge clk_sys_i);
		link_req <= 1'b1;
		fault <= 1'b1;
		fcode <= 16'h1020;
		fndig <= 3'h4;
		@(posedge clk_sys_i);
		fault <= 1'b0;
		fcode <= 16'(rnd());
		capture(7000, 1'b0);
		check_code(16'h1020, 4);
		$display("test four digit code done");
		report_and_stop();
	end
endmodule

/* sim/upstream_unit.sv */
// Upstream safety unit whose safety output feeds the AND-link input
`timescale 1ns/1ps
module upstream_unit (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic out_req_i,
	output logic and_link_o
);
	// Registered like a real safety output, so the link lags one cycle
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			and_link_o <= 1'b0;
		end else begin
			and_link_o <= out_req_i;
		end
	end
endmodule
